// [verilog/sse_top.sv]
// Purpose: Supply sequencing engine with input conditioning, drivers and AHB-Lite registers.
// Assumes: Comparator and pin inputs are synchronous to i_clk.
// Notes:   Engine and conditioning stay cleared until software latches the configuration.
// Operation
// [R1] Analog dual-function input uses one fixed low range, no selection.
// [R2] Logic-mode input n turns its detector into warning on supply n.
// [R3] Secondary detector range equals primary range of its supply.
// [R4] Warnings are readable and ORed into one engine warning.
// [R5] Combined warning includes converter limits and feeds all three exits.
// [R6] Logic inputs select level or edge; level follows filtered input.
// [R7] Edge mode emits one pulse, width 0 to 100 us.
// [R8] Logic inputs pass through the same glitch filter first.
// [R9] Glitch filter drops pulses under timeout and delays others by it.
// [R10] Each logic input has a switchable weak pull-down.
// [R11] Each driver has a drive mode; charge pump only on outputs 1-6.
// [R12] Driver data comes from engine, host value or internal clock.
// [R13] An internal 100 kHz clock can drive any output.
// [R14] Before configuration is latched, drivers stay weakly pulled low.
// [R15] Engine has 63 state cells; any state may go to any other.
// [R16] Every state watches all 10 fault detectors as exit conditions.
// [R17] Each state exits by sequence, monitored fault or timeout.
// [R18] Per-state sequence and timeout delays, reloaded per change, 0-400 ms.
// [R19] Outputs stay at the state's fixed levels while in the state.
// [R20] A state transition, including definition load, ends within 20 us.
// [R21] Host jump forces the programmed next state via sequence path.
// [R22] Timeout exit fires when condition unmet once the delay elapsed.
// [R23] Monitored-fault exit has no delay.
// [R24] One fault latch bit per input, recording enabled per state.
// [R25] Exit priority is monitor, then timeout, then sequence.
// [R26] Engine and conditioning timers held cleared until configuration loaded.
`timescale 1ns/10ps
`include "sse_consts.svh"

module sse_top
  import sse_pkg::*;
#(
  parameter int NSUP = 5,
  parameter int NOUT = 10
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [NSUP-1:0] i_sup_cmp,
  input wire logic [NSUP-1:0] i_dfi_cmp,
  input wire logic [NSUP-1:0] i_dfi_pin,
  input wire logic i_conv_warn,
  output logic [NSUP-1:0] o_dfi_pd_en,
  output logic [2*NSUP-1:0] o_sup_range,
  output logic [2*NSUP-1:0] o_warn_range,
  output logic [2*NSUP-1:0] o_dfi_range,
  output logic [NOUT-1:0] o_drv_data,
  output logic [3*NOUT-1:0] o_drv_mode
);
  localparam int NCH = 3 * NSUP;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] rd_data;
  logic [31:0] hrdata_ff;
  logic wr_ph_ff;
  logic [7:0] wr_addr_ff;
  logic cfg_ff;
  logic jump_ff;
  logic [9:0] fault_ff;
  logic [NSUP-1:0] dfi_logic_ff;
  logic [NSUP-1:0] dfi_edge_ff;
  logic [NSUP-1:0] dfi_fall_ff;
  logic [NSUP-1:0] dfi_pd_ff;
  logic [6:0] gf_us_ff;
  logic [6:0] pw_us_ff;
  logic [2*NSUP-1:0] range_ff;
  logic [5*NOUT-1:0] drv_cfg_ff;
  logic [NOUT-1:0] host_ff;
  logic [5:0] stsel_ff;
  logic [31:0] st_mem [0:255];
  logic acc;
  logic wr;
  logic [7:0] st_idx;
  logic [15:0] ev;
  logic [NSUP-1:0] warn;
  logic warn_any;
  logic [5:0] cur_ff;
  sse_eng_t eng_ff;
  logic jump_take;
  logic [9:0] fault_set;

  assign acc = i_hsel & i_hready & i_htrans[1];
  assign wr = wr_ph_ff;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_hrdata = hrdata_ff;
  assign st_idx = (wr ? {stsel_ff, wr_addr_ff[3:2] - 2'h2} :
                  {stsel_ff, i_haddr[3:2] - 2'h2});

  // Write happens in the data phase, when hwdata is valid.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ph_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
    end else begin
      wr_ph_ff <= acc & i_hwrite;
      wr_addr_ff <= i_haddr[7:0];
    end
  end

  // Read data is captured at the address phase so hrdata comes from a flop.
  always_comb begin
    rd_data = 32'h0000_0000;
    case (i_haddr[7:0])
      `SSE_A_CTRL: rd_data[`SSE_CTRL_CFG] = cfg_ff;
      `SSE_A_STATUS: rd_data = {19'h0, eng_ff == SSE_ENG_LOAD, warn_any, warn, cur_ff};
      `SSE_A_FAULT: rd_data = {22'h0, fault_ff};
      `SSE_A_DFI: rd_data = {12'h0, dfi_pd_ff, dfi_fall_ff, dfi_edge_ff, dfi_logic_ff};
      `SSE_A_FILT: rd_data = {17'h0, pw_us_ff, 1'b0, gf_us_ff};
      `SSE_A_RANGE: rd_data = {22'h0, range_ff};
      `SSE_A_DRV_LO: rd_data = {2'h0, drv_cfg_ff[29:0]};
      `SSE_A_DRV_HI: rd_data = {12'h0, drv_cfg_ff[49:30]};
      `SSE_A_HOST: rd_data = {22'h0, host_ff};
      `SSE_A_STSEL: rd_data = {26'h0, stsel_ff};
      `SSE_A_INPUTS: rd_data = {16'h0, ev};
      default: begin
        if (i_haddr[7:0] >= `SSE_A_STW0 && i_haddr[7:0] <= `SSE_A_STW3) begin
          rd_data = st_mem[st_idx];
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (acc && !i_hwrite) begin
      hrdata_ff <= rd_data;
    end
  end

  // Configuration registers.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_ff <= 1'b0;
      dfi_logic_ff <= '0;
      dfi_edge_ff <= '0;
      dfi_fall_ff <= '0;
      dfi_pd_ff <= '0;
      gf_us_ff <= 7'h00;
      pw_us_ff <= 7'h00;
      range_ff <= '0;
      drv_cfg_ff <= '0;
      host_ff <= '0;
      stsel_ff <= 6'h00;
    end else if (wr) begin
      case (wr_addr_ff)
        `SSE_A_CTRL: cfg_ff <= i_hwdata[`SSE_CTRL_CFG];
        `SSE_A_DFI: begin
          dfi_logic_ff <= i_hwdata[4:0];
          dfi_edge_ff <= i_hwdata[9:5];
          dfi_fall_ff <= i_hwdata[14:10];
          dfi_pd_ff <= i_hwdata[19:15];
        end
        `SSE_A_FILT: begin
          gf_us_ff <= i_hwdata[6:0];
          pw_us_ff <= i_hwdata[14:8];
        end
        `SSE_A_RANGE: range_ff <= i_hwdata[9:0];
        `SSE_A_DRV_LO: drv_cfg_ff[29:0] <= i_hwdata[29:0];
        `SSE_A_DRV_HI: drv_cfg_ff[49:30] <= i_hwdata[19:0];
        `SSE_A_HOST: host_ff <= i_hwdata[9:0];
        `SSE_A_STSEL: stsel_ff <= i_hwdata[5:0];
        default: ;
      endcase
    end
  end

  // State-cell store; cell 63 is never entered.
  always_ff @(posedge i_clk) begin
    if (wr && wr_addr_ff >= `SSE_A_STW0 && wr_addr_ff <= `SSE_A_STW3) begin
      st_mem[st_idx] <= i_hwdata; // [R15]
    end
  end

  // Jump request stays pending until the engine consumes it or the configuration bit is cleared.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      jump_ff <= 1'b0;
    end else if (wr && wr_addr_ff == `SSE_A_CTRL && i_hwdata[`SSE_CTRL_JUMP]) begin
      jump_ff <= 1'b1; // [R21]
    end else if (jump_take || !cfg_ff) begin
      jump_ff <= 1'b0;
    end
  end

  // Fault latch, write one to clear; a new fault wins over the clear.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      fault_ff <= 10'h000;
    end else if (wr && wr_addr_ff == `SSE_A_FAULT) begin
      fault_ff <= (fault_ff & ~i_hwdata[9:0]) | fault_set; // [R24]
    end else begin
      fault_ff <= fault_ff | fault_set;
    end
  end

  // ----------------------------------------------------------------
  // Input conditioning
  // ----------------------------------------------------------------
  logic [5:0] us_div_ff;
  logic us_tick;
  logic [NCH-1:0] raw;
  logic [NCH-1:0] filt_ff;
  logic [NSUP-1:0] filt_pin_d_ff;
  logic [NSUP-1:0] pulse_ff;
  logic [NSUP-1:0] logic_sig;
  logic [9:0] supply_fault_detector;

  assign us_tick = (us_div_ff == 6'(`SSE_US_TICK_CYC - 1));
  assign raw = {i_dfi_pin, i_dfi_cmp, i_sup_cmp};

  // Shared microsecond tick; held still while unconfigured.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      us_div_ff <= 6'h00;
    end else if (!cfg_ff || us_tick) begin
      us_div_ff <= 6'h00; // [R26]
    end else begin
      us_div_ff <= us_div_ff + 6'h01;
    end
  end

  // The same filter serves detectors and logic pins alike.
  for (genvar g = 0; g < NCH; g++) begin : g_filt
    logic [6:0] cnt_ff;
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        cnt_ff <= 7'h00;
        filt_ff[g] <= 1'b0;
      end else if (!cfg_ff) begin
        cnt_ff <= 7'h00;
        filt_ff[g] <= 1'b0; // [R26]
      end else if (raw[g] == filt_ff[g]) begin
        cnt_ff <= 7'h00; // [R9]
      end else if (cnt_ff >= gf_us_ff) begin
        filt_ff[g] <= raw[g]; // [R8] [R9]
        cnt_ff <= 7'h00;
      end else if (us_tick) begin
        cnt_ff <= cnt_ff + 7'h01;
      end
    end
  end

  // Edge detection produces a pulse; a zero width gives a single cycle.
  for (genvar g = 0; g < NSUP; g++) begin : g_edge
    logic [6:0] pw_ff;
    logic hit;
    assign hit = dfi_fall_ff[g] ? (filt_pin_d_ff[g] & ~filt_ff[10+g]) :
                 (~filt_pin_d_ff[g] & filt_ff[10+g]);
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        pulse_ff[g] <= 1'b0;
        pw_ff <= 7'h00;
        filt_pin_d_ff[g] <= 1'b0;
      end else if (!cfg_ff) begin
        pulse_ff[g] <= 1'b0;
        pw_ff <= 7'h00;
        filt_pin_d_ff[g] <= 1'b0;
      end else begin
        filt_pin_d_ff[g] <= filt_ff[10+g];
        if (hit) begin
          pulse_ff[g] <= 1'b1; // [R7]
          pw_ff <= 7'h00;
        end else if (pulse_ff[g] && pw_ff >= pw_us_ff) begin
          pulse_ff[g] <= 1'b0;
        end else if (pulse_ff[g] && us_tick) begin
          pw_ff <= pw_ff + 7'h01;
        end
      end
    end
    assign logic_sig[g] = dfi_logic_ff[g] &
                          (dfi_edge_ff[g] ? pulse_ff[g] : filt_ff[10+g]); // [R6]
  end

  // Detector of a logic-mode input becomes the warning of its supply.
  assign warn = filt_ff[9:5] & dfi_logic_ff; // [R2]
  assign warn_any = (|warn) | i_conv_warn; // [R4] [R5]
  assign supply_fault_detector = {filt_ff[9:5] & ~dfi_logic_ff, filt_ff[4:0]};
  assign ev = {warn_any, logic_sig, supply_fault_detector}; // [R16]
  assign o_dfi_pd_en = dfi_pd_ff & dfi_logic_ff & {NSUP{cfg_ff}}; // [R10]
  assign o_sup_range = range_ff;
  assign o_warn_range = range_ff; // [R3]
  assign o_dfi_range = {NSUP{`SSE_RANGE_LOW}}; // [R1]

  // ----------------------------------------------------------------
  // Sequencing engine
  // ----------------------------------------------------------------
  sse_def_t def_ff;
  sse_def_t nxt_def;
  logic [5:0] ld_cnt_ff;
  logic [8:0] tdiv_ff;
  logic [15:0] el_ff;
  logic seq_cond;
  logic mon_hit;
  logic seq_exit;
  logic tmo_exit;
  logic [5:0] nxt_state;

  assign nxt_def = {st_mem[{cur_ff, 2'h3}], st_mem[{cur_ff, 2'h2}],
                    st_mem[{cur_ff, 2'h1}], st_mem[{cur_ff, 2'h0}]};
  assign seq_cond = def_ff.seq_en &
                    (((ev ^ def_ff.seq_pol) & def_ff.seq_mask) == 16'h0000);
  assign mon_hit = |((ev ^ def_ff.mon_pol) & def_ff.mon_mask); // [R23]
  assign seq_exit = (seq_cond && el_ff >= def_ff.seq_dly) || jump_ff; // [R21]
  assign tmo_exit = def_ff.tmo_en && !seq_cond && !jump_ff &&
                    el_ff >= def_ff.tmo_dly; // [R22]
  assign jump_take = (eng_ff == SSE_ENG_RUN) && jump_ff && !mon_hit;
  assign fault_set = (eng_ff == SSE_ENG_RUN && def_ff.rec_en) ? supply_fault_detector : 10'h000;

  // Exit selection, monitor first, then timeout, then sequence.
  always_comb begin
    nxt_state = cur_ff;
    if (mon_hit) begin
      nxt_state = def_ff.mon_nxt; // [R25]
    end else if (tmo_exit) begin
      nxt_state = def_ff.tmo_nxt;
    end else if (seq_exit) begin
      nxt_state = def_ff.seq_nxt; // [R17]
    end
    if (nxt_state > `SSE_MAX_STATE) begin
      nxt_state = 6'h00;
    end
  end

  // Load waits a fixed few cycles, well inside the transition budget.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      eng_ff <= SSE_ENG_OFF;
      cur_ff <= 6'h00;
      ld_cnt_ff <= 6'h00;
      def_ff <= '0;
    end else if (!cfg_ff) begin
      eng_ff <= SSE_ENG_OFF; // [R26]
      cur_ff <= 6'h00;
      def_ff <= '0;
    end else begin
      case (eng_ff)
        SSE_ENG_OFF: begin
          eng_ff <= SSE_ENG_LOAD;
          ld_cnt_ff <= 6'h00;
        end
        SSE_ENG_LOAD: begin
          if (ld_cnt_ff == 6'(`SSE_LOAD_CYC - 1)) begin
            def_ff <= nxt_def; // [R20]
            eng_ff <= SSE_ENG_RUN;
          end else begin
            ld_cnt_ff <= ld_cnt_ff + 6'h01;
          end
        end
        SSE_ENG_RUN: begin
          if (mon_hit || tmo_exit || seq_exit) begin
            cur_ff <= nxt_state; // [R15]
            eng_ff <= SSE_ENG_LOAD;
            ld_cnt_ff <= 6'h00;
          end
        end
        default: eng_ff <= SSE_ENG_OFF;
      endcase
    end
  end

  // Elapsed time in 10 us steps, restarted whenever a new state is active.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tdiv_ff <= 9'h000;
      el_ff <= 16'h0000;
    end else if (eng_ff != SSE_ENG_RUN) begin
      tdiv_ff <= 9'h000; // [R18]
      el_ff <= 16'h0000;
    end else if (tdiv_ff == 9'(`SSE_TMR_TICK_CYC - 1)) begin
      tdiv_ff <= 9'h000;
      if (el_ff != 16'hffff) begin
        el_ff <= el_ff + 16'h0001;
      end
    end else begin
      tdiv_ff <= tdiv_ff + 9'h001;
    end
  end

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  logic [7:0] ck_div_ff;
  logic ck_ff;

  // Internal clock; square wave, toggled every half period.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ck_div_ff <= 8'h00;
      ck_ff <= 1'b0;
    end else if (ck_div_ff == 8'(`SSE_CLKOUT_HALF_CYC - 1)) begin
      ck_div_ff <= 8'h00;
      ck_ff <= ~ck_ff; // [R13]
    end else begin
      ck_div_ff <= ck_div_ff + 8'h01;
    end
  end

  // Engine-sourced drivers hold the state's levels; charge pump falls back to push-pull on 7-10.
  for (genvar g = 0; g < NOUT; g++) begin : g_drv
    logic [1:0] src;
    logic [2:0] md;
    assign src = drv_cfg_ff[5*g +: 2];
    assign md = drv_cfg_ff[5*g+2 +: 3];
    always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        o_drv_data[g] <= 1'b0;
        o_drv_mode[3*g +: 3] <= SSE_DRV_WEAK_PD;
      end else if (!cfg_ff) begin
        o_drv_data[g] <= 1'b0; // [R14]
        o_drv_mode[3*g +: 3] <= SSE_DRV_WEAK_PD;
      end else begin
        case (src)
          `SSE_SRC_HOST: o_drv_data[g] <= host_ff[g]; // [R12]
          `SSE_SRC_CLK: o_drv_data[g] <= ck_ff;
          default: o_drv_data[g] <= def_ff.outs[g]; // [R19]
        endcase
        if (g >= 6 && md == SSE_DRV_CHPUMP) begin
          o_drv_mode[3*g +: 3] <= SSE_DRV_PP_VDD; // [R11]
        end else begin
          o_drv_mode[3*g +: 3] <= md;
        end
      end
    end
  end
endmodule

// [verilog/sse_consts.svh]
// Purpose: Offsets, field positions, codes and timing counts for the sequencer.
// Assumes: 32-bit AHB-Lite register words at byte offsets.
// Notes:   Definitions only.
`ifndef SSE_CONSTS_SVH
`define SSE_CONSTS_SVH
`define SSE_CLK_MHZ 50
`define SSE_US_TICK_NS 1000
`define SSE_US_TICK_CYC ((`SSE_US_TICK_NS * `SSE_CLK_MHZ) / 1000)
`define SSE_TMR_TICK_NS 10000
`define SSE_TMR_TICK_CYC ((`SSE_TMR_TICK_NS * `SSE_CLK_MHZ) / 1000)
`define SSE_CLKOUT_NS 10000
`define SSE_CLKOUT_HALF_CYC ((`SSE_CLKOUT_NS * `SSE_CLK_MHZ) / 2000)
`define SSE_LOAD_NS 400
`define SSE_LOAD_CYC ((`SSE_LOAD_NS * `SSE_CLK_MHZ) / 1000)
`define SSE_MAX_STATE 6'd62
`define SSE_A_CTRL 8'h00
`define SSE_A_STATUS 8'h04
`define SSE_A_FAULT 8'h08
`define SSE_A_DFI 8'h0c
`define SSE_A_FILT 8'h10
`define SSE_A_RANGE 8'h14
`define SSE_A_DRV_LO 8'h18
`define SSE_A_DRV_HI 8'h1c
`define SSE_A_HOST 8'h20
`define SSE_A_STSEL 8'h24
`define SSE_A_STW0 8'h28
`define SSE_A_STW3 8'h34
`define SSE_A_INPUTS 8'h38
`define SSE_CTRL_CFG 0
`define SSE_CTRL_JUMP 1
`define SSE_RANGE_LOW 2'h0
`define SSE_SRC_SE 2'h0
`define SSE_SRC_HOST 2'h1
`define SSE_SRC_CLK 2'h2
`endif

// [verilog/sse_pkg.sv]
// Purpose: Types shared by the supply sequencing engine.
// Assumes: Constants come from sse_consts.svh.
// Notes:   One state definition is four 32-bit words.
package sse_pkg;
  typedef enum logic [2:0] {
    SSE_DRV_WEAK_PD = 3'h0,
    SSE_DRV_OD = 3'h1,
    SSE_DRV_OD_PU_VDD = 3'h2,
    SSE_DRV_PP_VDD = 3'h3,
    SSE_DRV_OD_PU_VP = 3'h4,
    SSE_DRV_PP_VP = 3'h5,
    SSE_DRV_STRONG_PD = 3'h6,
    SSE_DRV_CHPUMP = 3'h7
  } sse_drv_t;
  typedef enum logic [2:0] {
    SSE_ENG_OFF = 3'b001,
    SSE_ENG_LOAD = 3'b010,
    SSE_ENG_RUN = 3'b100
  } sse_eng_t;
  typedef struct packed {
    logic [15:0] tmo_dly;
    logic [15:0] seq_dly;
    logic [15:0] mon_pol;
    logic [15:0] mon_mask;
    logic [15:0] seq_pol;
    logic [15:0] seq_mask;
    logic rsvd;
    logic seq_en;
    logic tmo_en;
    logic [5:0] mon_nxt;
    logic [5:0] tmo_nxt;
    logic [5:0] seq_nxt;
    logic rec_en;
    logic [9:0] outs;
  } sse_def_t;
endpackage

// [verif/sse_top_sva.sv]
// Purpose: Port-level assertions for the supply sequencing engine.
// Assumes: Configuration bit shadowed from CTRL writes.
// Notes:   Bound to sse_top at the foot of this file.
`timescale 1ns/10ps
`include "sse_consts.svh"

module sse_chk #(
  parameter int NSUP = 5,
  parameter int NOUT = 10
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic [NSUP-1:0] o_dfi_pd_en,
  input wire logic [2*NSUP-1:0] o_sup_range,
  input wire logic [2*NSUP-1:0] o_warn_range,
  input wire logic [2*NSUP-1:0] o_dfi_range,
  input wire logic [NOUT-1:0] o_drv_data,
  input wire logic [3*NOUT-1:0] o_drv_mode
);
  logic acc;
  logic rd_req;
  logic wr_ctrl_ff;
  logic cfg_ff;
  logic cp_hi;

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  // A transfer is taken on select, ready and active htrans.
  assign acc = i_hsel && i_hready && i_htrans[1];
  assign rd_req = acc && !i_hwrite;

  // The shadow bit lands at the data phase end, as the register does.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_ctrl_ff <= 1'b0;
      cfg_ff <= 1'b0;
    end else begin
      wr_ctrl_ff <= acc && i_hwrite && (i_haddr[7:0] == `SSE_A_CTRL);
      if (wr_ctrl_ff) begin
        cfg_ff <= i_hwdata[`SSE_CTRL_CFG];
      end
    end
  end

  // Outputs 7 to 10 have no charge pump.
  always_comb begin
    cp_hi = 1'b0;
    for (int k = 6; k < NOUT; k++) begin
      cp_hi = cp_hi | (o_drv_mode[3*k +: 3] == 3'h7);
    end
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);

  sequence ctrl_rd_s;
    rd_req && (i_haddr[7:0] == `SSE_A_CTRL);
  endsequence

  sequence unmap_rd_s;
    rd_req && (i_haddr[7:0] > `SSE_A_INPUTS);
  endsequence

  dfi_range_a: assert property (o_dfi_range == '0)
    else $error("dual-function range not low");
  warn_range_a: assert property (o_warn_range == o_sup_range)
    else $error("warning range differs from supply range");
  pd_cfg_a: assert property (o_dfi_pd_en != '0 |-> cfg_ff)
    else $error("pull-down enabled before configuration");
  no_chpump_a: assert property (!cp_hi)
    else $error("charge pump on outputs 7 to 10");
  drv_idle_a: assert property (
    !cfg_ff && !$past(cfg_ff) |-> o_drv_mode == '0 && o_drv_data == '0)
    else $error("drivers active before configuration");
  drv_fall_a: assert property (
    $fell(cfg_ff) |-> ##[1:2] (o_drv_mode == '0 && o_drv_data == '0))
    else $error("drivers not idle after unconfigure");
  ctrl_rd_a: assert property (ctrl_rd_s |=> o_hrdata[1:0] == {1'b0, $past(cfg_ff)})
    else $error("control read wrong");
  unmap_rd_a: assert property (unmap_rd_s |=> o_hrdata == '0)
    else $error("unmapped read returned nonzero data");
endmodule

bind sse_top sse_chk #(.NSUP(NSUP), .NOUT(NOUT)) u_chk (
  .i_clk(i_clk), .i_nrst(i_nrst), .i_hsel(i_hsel), .i_haddr(i_haddr),
  .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hwdata(i_hwdata), .i_hready(i_hready),
  .o_hrdata(o_hrdata), .o_dfi_pd_en(o_dfi_pd_en), .o_sup_range(o_sup_range),
  .o_warn_range(o_warn_range), .o_dfi_range(o_dfi_range), .o_drv_data(o_drv_data),
  .o_drv_mode(o_drv_mode));

// [verif/sse_rail_model.sv]
// Purpose: Board model of five regulators fed by the first five driver outputs.
// Assumes: A rail is good RISE cycles after its enable rises.
// Notes:   A shorted rail stays faulted.
`timescale 1ns/10ps

module sse_rail_model #(
  parameter int RISE = 100
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [9:0] i_drv_data,
  input wire logic [29:0] i_drv_mode,
  input wire logic [4:0] i_short,
  output logic [4:0] o_fault
);
  logic [4:0][7:0] up_ff;

  // A low or pulled-down pin drops its rail; a high pin ramps it.
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      up_ff <= '0;
    end else begin
      for (int k = 0; k < 5; k++) begin
        if (!i_drv_data[k] || (i_drv_mode[3*k +: 3] inside {3'h0, 3'h6})) begin
          up_ff[k] <= 8'h0;
        end else if (up_ff[k] != 8'(RISE)) begin
          up_ff[k] <= up_ff[k] + 8'h1;
        end
      end
    end
  end

  // Faulted until the ramp completes, or when shorted.
  always_comb begin
    for (int k = 0; k < 5; k++) begin
      o_fault[k] = i_short[k] || (up_ff[k] != 8'(RISE));
    end
  end
endmodule

// [verif/testbench.sv]
// Purpose: Self-checking bench for the supply sequencing engine.
// Assumes: Rails come from sse_rail_model.
// Notes:   Register rows first, then engine, warning and input cases.
`timescale 1ns/10ps
`include "sse_consts.svh"

module testbench import sse_pkg::*; ;
  typedef struct packed {
    logic [7:0] a;
    logic [31:0] w;
    logic [31:0] e;
  } sse_row_t;
  sse_row_t rows [5] = '{'{`SSE_A_RANGE, 32'h3ff, 32'h3ff}, '{`SSE_A_FILT, 32'h200, 32'h200},
    '{`SSE_A_HOST, 32'h2aa, 32'h2aa}, '{`SSE_A_STSEL, 32'h3e, 32'h3e},
    '{8'h3c, 32'hffffffff, 32'h0}};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic [4:0] dfi_cmp = '0;
  logic [4:0] dfi_pin = '0;
  logic conv_warn = 1'b0;
  logic [4:0] short = '0;
  logic [31:0] hrdata;
  logic hready;
  logic [4:0] sup_cmp;
  logic [4:0] pd_en;
  logic [9:0] sup_rng;
  logic [9:0] warn_rng;
  logic [9:0] drv;
  logic [29:0] mode;
  logic [31:0] rd;
  time t0;
  int miscompares = 0;
  int num_checks = 0;
  int n;

  // Free-running 50 MHz clock.
  initial begin
    forever #10 clk = ~clk;
  end

  sse_top u_dut (.i_clk(clk), .i_nrst(nrst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
    .i_sup_cmp(sup_cmp), .i_dfi_cmp(dfi_cmp), .i_dfi_pin(dfi_pin), .i_conv_warn(conv_warn),
    .o_dfi_pd_en(pd_en), .o_sup_range(sup_rng), .o_warn_range(warn_rng), .o_dfi_range(),
    .o_drv_data(drv), .o_drv_mode(mode));
  sse_rail_model u_rails (.i_clk(clk), .i_nrst(nrst), .i_drv_data(drv), .i_drv_mode(mode),
    .i_short(short), .o_fault(sup_cmp));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: saw %h wanted %h", $time, got, exp);
    end
  endtask

  // Single word transfer, each phase held until hready.
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic prog(input logic [5:0] s, input logic [31:0] w0, w1, w2, w3);
    bus(1'b1, `SSE_A_STSEL, {26'h0, s});
    bus(1'b1, `SSE_A_STW0, w0);
    bus(1'b1, `SSE_A_STW0 + 8'h4, w1);
    bus(1'b1, `SSE_A_STW0 + 8'h8, w2);
    bus(1'b1, `SSE_A_STW3, w3);
  endtask

  // Bounded wait for an engine output pattern.
  task automatic wait_drv(input logic [7:0] e, input int lim);
    n = 0;
    while (drv[7:0] !== e && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(drv[7:0], e);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(drv, '0);
    rdchk(`SSE_A_CTRL, 32'h0);
    rdchk(`SSE_A_FAULT, 32'h0);
    foreach (rows[i]) begin
      bus(1'b1, rows[i].a, rows[i].w);
      rdchk(rows[i].a, rows[i].e);
    end
    chk(warn_rng, 32'h3ff);
    // Outputs 0-7 engine, 8 host with pump, 9 clock.
    bus(1'b1, `SSE_A_DRV_LO, 32'h18c6318c);
    bus(1'b1, `SSE_A_DRV_HI, 32'h0007758c);
    bus(1'b1, `SSE_A_HOST, 32'h100);
    prog(6'd0, 32'h40000801, 32'h1, 32'h0, 32'h0);
    prog(6'd1, 32'h7f061003, 32'h2, 32'h1, 32'h50000);
    prog(6'd3, 32'h40002004, 32'h2, 32'h0, 32'h0);
    prog(6'd4, 32'h628c0408, 32'h10, 32'h10, 32'h0);
    prog(6'd5, 32'h10, 32'h0, 32'h0, 32'h0);
    chk(mode, '0);
    short <= 5'h02;
    bus(1'b1, `SSE_A_CTRL, 32'h1);
    wait_drv(8'h01, 60);
    chk(drv[8], 1'b1);
    chk(mode[26:24], SSE_DRV_PP_VDD);
    wait_drv(8'h03, 1000);
    repeat (1500) @(posedge clk);
    chk(drv[7:0], 8'h03);
    wait_drv(8'h04, 1200);
    repeat (200) @(posedge clk);
    chk(drv[7:0], 8'h04);
    bus(1'b1, `SSE_A_CTRL, 32'h3);
    wait_drv(8'h10, 1000);
    bus(1'b0, `SSE_A_STATUS, 32'h0);
    chk(rd[5:0], 6'd5);
    bus(1'b0, `SSE_A_FAULT, 32'h0);
    chk(rd[4], 1'b1);
    bus(1'b1, `SSE_A_FAULT, 32'h3ff);
    rdchk(`SSE_A_FAULT, 32'h0);
    @(drv[9]);
    t0 = $time;
    @(drv[9]);
    chk(32'(($time - t0) / 20), 32'd250);
    // Warnings from logic inputs and converter.
    bus(1'b1, `SSE_A_DFI, 32'h000f801f);
    @(posedge clk);
    chk(pd_en, 5'h1f);
    dfi_cmp <= 5'h04;
    repeat (4) @(posedge clk);
    bus(1'b0, `SSE_A_STATUS, 32'h0);
    chk(rd[11:6], 6'h24);
    dfi_cmp <= 5'h00;
    conv_warn <= 1'b1;
    repeat (4) @(posedge clk);
    bus(1'b0, `SSE_A_STATUS, 32'h0);
    chk(rd[11:6], 6'h20);
    conv_warn <= 1'b0;
    // A 4 us filter: short pulse lost, long one late.
    bus(1'b1, `SSE_A_FILT, 32'h204);
    dfi_pin <= 5'h01;
    repeat (100) @(posedge clk);
    dfi_pin <= 5'h00;
    repeat (150) @(posedge clk);
    rdchk(`SSE_A_INPUTS, 32'hf);
    dfi_pin <= 5'h01;
    repeat (50) @(posedge clk);
    bus(1'b0, `SSE_A_INPUTS, 32'h0);
    chk(rd[10], 1'b0);
    repeat (250) @(posedge clk);
    bus(1'b0, `SSE_A_INPUTS, 32'h0);
    chk(rd[10], 1'b1);
    // Rising edge, 2 us pulse, read every third cycle.
    bus(1'b1, `SSE_A_DFI, 32'h000f803f);
    dfi_pin <= 5'h00;
    repeat (400) @(posedge clk);
    dfi_pin <= 5'h01;
    n = 0;
    repeat (150) begin
      bus(1'b0, `SSE_A_INPUTS, 32'h0);
      n += int'(rd[10] === 1'b1);
    end
    chk(32'(n >= 30 && n <= 52), 32'h1);
    chk(rd[10], 1'b0);
    bus(1'b1, `SSE_A_DFI, 32'h000f8000);
    @(posedge clk);
    chk(pd_en, 5'h00);
    bus(1'b1, `SSE_A_CTRL, 32'h0);
    repeat (3) @(posedge clk);
    chk(32'({mode, drv} != '0), 32'h0);
    test_done();
  end

  // Hang guard, about eight times the run.
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule
